// >>> verilog/mox_pkg.sv
// shared constants and types for the move/or instruction executor
`default_nettype none
package mox_pkg;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 7;
    localparam int unsigned WORD_W = 14;
    localparam int unsigned FILE_DEPTH = 128;
    localparam int unsigned OPC_W = 6;
    localparam int unsigned LIT_PFX_W = 4;

    // field positions inside an instruction word
    localparam int unsigned OPC_LSB = 8;
    localparam int unsigned DEST_BIT = 7;
    localparam int unsigned LIT_PFX_LSB = 10;

    // opcode encodings, upper six bits of the word; the literal prefix is the upper four
    localparam logic [OPC_W-1:0] OPC_OR_ACC_INTO_FILE = 6'h04;
    localparam logic [OPC_W-1:0] OPC_COPY_FILE = 6'h08;
    localparam logic [OPC_W-1:0] OPC_SYSTEM = 6'h00;
    localparam logic [LIT_PFX_W-1:0] LIT_PFX_LOAD_LITERAL_ACC = 4'hC;
    // lower seven bits of a system word that mean idle_op
    localparam logic [ADDR_W-1:0] IDLE_OP_LOW = 7'h00;

    // destination select values
    localparam logic DEST_ACC = 1'b0;
    localparam logic DEST_FILE = 1'b1;

    // reset values
    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
    localparam logic [DATA_W-1:0] FILE_RESET = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 7'h00;
    localparam logic ZERO_RESET = 1'b0;

    typedef enum logic [2:0] {
        MOX_OP_IDLE = 3'b000,
        MOX_OP_OR = 3'b001,
        MOX_OP_COPY = 3'b010,
        MOX_OP_STORE = 3'b011,
        MOX_OP_LIT = 3'b100,
        MOX_OP_BAD = 3'b101
    } mox_op_type;
endpackage : mox_pkg
`default_nettype wire

// >>> verilog/mox_dec_if.sv
// carrier between the decoder and the executor
`timescale 1ns/1ps
`default_nettype none
interface mox_dec_if;
    logic [mox_pkg::WORD_W-1:0] word;
    mox_pkg::mox_op_type op;
    logic [mox_pkg::ADDR_W-1:0] file_addr;
    logic dest;
    logic [mox_pkg::DATA_W-1:0] literal;

    modport exec (output word, input op, input file_addr, input dest,
        input literal);
    modport dec (input word, output op, output file_addr, output dest,
        output literal);
endinterface : mox_dec_if
`default_nettype wire

// >>> verilog/mox_decode.sv
// combinational instruction word decoder
`timescale 1ns/1ps
`default_nettype none
module mox_decode (
    mox_dec_if.dec dec
);
    logic [mox_pkg::OPC_W-1:0] opc;
    logic [mox_pkg::LIT_PFX_W-1:0] lit_pfx;

    assign opc = dec.word[mox_pkg::OPC_LSB +: mox_pkg::OPC_W];
    assign lit_pfx = dec.word[mox_pkg::LIT_PFX_LSB +: mox_pkg::LIT_PFX_W];
    assign dec.file_addr = dec.word[mox_pkg::ADDR_W-1:0];
    assign dec.dest = dec.word[mox_pkg::DEST_BIT];
    assign dec.literal = dec.word[mox_pkg::DATA_W-1:0];

    always_comb begin
        dec.op = mox_pkg::MOX_OP_BAD;
        // literal prefix ignores the two bits below it
        if (lit_pfx == mox_pkg::LIT_PFX_LOAD_LITERAL_ACC) begin
            dec.op = mox_pkg::MOX_OP_LIT;
        end else if (opc == mox_pkg::OPC_OR_ACC_INTO_FILE) begin
            dec.op = mox_pkg::MOX_OP_OR;
        end else if (opc == mox_pkg::OPC_COPY_FILE) begin
            dec.op = mox_pkg::MOX_OP_COPY;
        end else if (opc == mox_pkg::OPC_SYSTEM) begin
            if (dec.dest == mox_pkg::DEST_FILE) begin
                dec.op = mox_pkg::MOX_OP_STORE;
            end else if (dec.file_addr == mox_pkg::IDLE_OP_LOW) begin
                dec.op = mox_pkg::MOX_OP_IDLE;
            end
        end
    end
endmodule : mox_decode
`default_nettype wire

// >>> verilog/mox_exec.sv
// single-cycle executor for or, copy, store, literal and idle instructions
`timescale 1ns/1ps
`default_nettype none
module mox_exec (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire logic [mox_pkg::WORD_W-1:0] instr_word,
    output logic [mox_pkg::DATA_W-1:0] acc,
    output logic zero_flag,
    output logic done,
    output logic bad_op,
    output logic file_we,
    output logic [mox_pkg::ADDR_W-1:0] file_addr,
    output logic [mox_pkg::DATA_W-1:0] file_data
);
    ////////////////////////////////////////////////////////////////////////
    mox_dec_if dbus ();

    assign dbus.word = instr_word;

    mox_decode u_decode (
        .dec(dbus.dec)
    );

    function automatic logic is_zero(input logic [mox_pkg::DATA_W-1:0] v);
        return v == '0;
    endfunction : is_zero

    ////////////////////////////////////////////////////////////////////////
    // file register array, read combinationally within the same cycle
    logic [mox_pkg::DATA_W-1:0] file_mem [mox_pkg::FILE_DEPTH];
    logic [mox_pkg::DATA_W-1:0] rd_data;

    assign rd_data = file_mem[dbus.file_addr];

    ////////////////////////////////////////////////////////////////////////
    logic [mox_pkg::DATA_W-1:0] next_acc;
    logic next_zero_flag;
    logic next_done;
    logic next_bad_op;
    logic next_file_we;
    logic [mox_pkg::ADDR_W-1:0] next_file_addr;
    logic [mox_pkg::DATA_W-1:0] next_file_data;
    logic [mox_pkg::DATA_W-1:0] result;

    always_comb begin
        next_acc = acc;
        next_zero_flag = zero_flag;
        next_done = 1'b0;
        next_bad_op = 1'b0;
        next_file_we = 1'b0;
        next_file_addr = file_addr;
        next_file_data = file_data;
        result = rd_data;
        if (instr_valid) begin
            next_done = 1'b1;
            unique case (dbus.op)
                mox_pkg::MOX_OP_OR,
                mox_pkg::MOX_OP_COPY: begin
                    if (dbus.op == mox_pkg::MOX_OP_OR) begin
                        result = acc | rd_data;
                    end else begin
                        result = rd_data;
                    end
                    next_zero_flag = is_zero(result);
                    if (dbus.dest == mox_pkg::DEST_FILE) begin
                        next_file_we = 1'b1;
                        next_file_addr = dbus.file_addr;
                        next_file_data = result;
                    end else begin
                        next_acc = result;
                    end
                end
                mox_pkg::MOX_OP_STORE: begin
                    next_file_we = 1'b1;
                    next_file_addr = dbus.file_addr;
                    next_file_data = acc;
                end
                mox_pkg::MOX_OP_LIT: begin
                    next_acc = dbus.literal;
                end
                mox_pkg::MOX_OP_IDLE: begin
                    // nothing moves
                end
                mox_pkg::MOX_OP_BAD: begin
                    // unknown words retire like idle_op but are reported
                    next_bad_op = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc <= mox_pkg::ACC_RESET;
            zero_flag <= mox_pkg::ZERO_RESET;
            done <= 1'b0;
            bad_op <= 1'b0;
            file_we <= 1'b0;
            file_addr <= mox_pkg::ADDR_RESET;
            file_data <= mox_pkg::FILE_RESET;
        end else begin
            acc <= next_acc;
            zero_flag <= next_zero_flag;
            done <= next_done;
            bad_op <= next_bad_op;
            file_we <= next_file_we;
            file_addr <= next_file_addr;
            file_data <= next_file_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write comes from the next values so a back-to-back read sees it
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < mox_pkg::FILE_DEPTH; i++) begin
                file_mem[i] <= mox_pkg::FILE_RESET;
            end
        end else if (next_file_we) begin
            file_mem[next_file_addr] <= next_file_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    or_to_acc_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        instr_valid && dbus.op == mox_pkg::MOX_OP_OR && !dbus.dest
        |=> acc == $past(acc | rd_data)
            && zero_flag == ($past(acc | rd_data) == '0))
        else $error("or into accumulator gave wrong value or zero");

    or_to_file_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        instr_valid && dbus.op == mox_pkg::MOX_OP_OR && dbus.dest
        |=> file_we && file_data == $past(acc | rd_data)
            && file_addr == $past(dbus.file_addr) && $stable(acc))
        else $error("or into file register misdirected");

    copy_value_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        instr_valid && dbus.op == mox_pkg::MOX_OP_COPY && !dbus.dest
        |=> acc == $past(rd_data) && !file_we)
        else $error("copy to accumulator lost the value");

    copy_zero_test_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        instr_valid && dbus.op == mox_pkg::MOX_OP_COPY && dbus.dest
        |=> zero_flag == ($past(rd_data) == '0)
            && file_data == $past(rd_data) && $stable(acc))
        else $error("copy back to file did not test for zero");

    store_acc_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        instr_valid && dbus.op == mox_pkg::MOX_OP_STORE
        |=> file_we && file_data == $past(acc) && $stable(zero_flag)
            && $stable(acc))
        else $error("store of accumulator wrong or touched flags");

    literal_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        instr_valid && dbus.op == mox_pkg::MOX_OP_LIT
        |=> acc == $past(instr_word[mox_pkg::DATA_W-1:0])
            && $stable(zero_flag) && !file_we)
        else $error("literal load wrong or touched flags");

    literal_zero_dc_a: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        instr_valid
            && instr_word[mox_pkg::LIT_PFX_LSB +: mox_pkg::LIT_PFX_W]
            == mox_pkg::LIT_PFX_LOAD_LITERAL_ACC
            && instr_word[mox_pkg::LIT_PFX_LSB-1:mox_pkg::OPC_LSB] == '0
        |=> done && !bad_op
            && acc == $past(instr_word[mox_pkg::DATA_W-1:0]))
        else $error("literal word with zero spare bits refused");

    idle_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        instr_valid && dbus.op == mox_pkg::MOX_OP_IDLE
        |=> $stable(acc) && $stable(zero_flag) && !file_we && !bad_op)
        else $error("idle instruction changed state");

    one_cycle_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        instr_valid |=> done ##1 (done == $past(instr_valid)))
        else $error("instruction did not retire in one cycle");

    ////////////////////////////////////////////////////////////////////////
    // write side and quiet cycles; the array is only visible through copy and or
    file_write_lands_a: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        file_we |-> file_mem[file_addr] == file_data)
        else $error("file register write did not land");

    or_keeps_file_a: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        instr_valid && dbus.op == mox_pkg::MOX_OP_OR && !dbus.dest
        |=> !file_we)
        else $error("or into accumulator wrote a file register");

    copy_acc_zero_a: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        instr_valid && dbus.op == mox_pkg::MOX_OP_COPY && !dbus.dest
        |=> zero_flag == ($past(rd_data) == '0))
        else $error("copy to accumulator did not set zero");

    store_target_a: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        instr_valid && dbus.op == mox_pkg::MOX_OP_STORE
        |=> file_addr == $past(dbus.file_addr))
        else $error("store of accumulator went to wrong register");

    bad_retires_a: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        instr_valid && dbus.op == mox_pkg::MOX_OP_BAD
        |=> done && bad_op && $stable(acc) && $stable(zero_flag)
            && !file_we)
        else $error("undecodable word changed state");

    bad_with_done_a: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        bad_op |-> done)
        else $error("bad word flagged without retiring");

    no_word_quiet_a: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        !instr_valid |=> !done && !bad_op && !file_we && $stable(acc)
            && $stable(zero_flag))
        else $error("state moved with no instruction");
endmodule : mox_exec
`default_nettype wire

// >>> verification/tb_top.sv
// self-checking bench for the move/or instruction executor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic instr_valid = 1'b0;
    logic [13:0] instr_word = 14'h0000;
    logic [7:0] acc;
    logic zero_flag;
    logic done;
    logic bad_op;
    logic file_we;
    logic [6:0] file_addr;
    logic [7:0] file_data;
    int n_errors = 0;
    int comparisons = 0;
    logic [7:0] mem [128];
    logic [7:0] acc_m = 8'h00;
    logic z_m = 1'b0;

    mox_exec mox_exec_inst (.sys_clk(sys_clk), .rst_n(rst_n),
        .instr_valid(instr_valid), .instr_word(instr_word), .acc(acc),
        .zero_flag(zero_flag), .done(done), .bad_op(bad_op),
        .file_we(file_we), .file_addr(file_addr), .file_data(file_data));

    initial begin
        forever #10 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] seen,
            input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic finish_test();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    // one word retired; bench keeps its own copy of acc, flag and memory
    task automatic step(input logic [13:0] w);
        logic [6:0] f;
        logic [7:0] r;
        logic we;
        logic bad;
        f = w[6:0];
        we = 1'b0;
        bad = 1'b0;
        r = 8'h00;
        if (w[13:10] == 4'hC) begin
            acc_m = w[7:0];
        end else if (w[13:8] == 6'h04 || w[13:8] == 6'h08) begin
            r = (w[13:8] == 6'h04) ? (acc_m | mem[f]) : mem[f];
            z_m = (r == 8'h00);
            we = w[7];
            if (w[7]) mem[f] = r;
            else acc_m = r;
        end else if (w[13:8] == 6'h00 && w[7]) begin
            we = 1'b1;
            r = acc_m;
            mem[f] = acc_m;
        end else begin
            bad = (w != 14'h0000);
        end
        instr_valid = 1'b1;
        instr_word = w;
        @(posedge sys_clk);
        @(negedge sys_clk);
        check("done", {7'h00, done}, 8'h01);
        check("bad_op", {7'h00, bad_op}, {7'h00, bad});
        check("acc", acc, acc_m);
        check("zero_flag", {7'h00, zero_flag}, {7'h00, z_m});
        check("file_we", {7'h00, file_we}, {7'h00, we});
        if (we) begin
            check("file_addr", {1'b0, file_addr}, {1'b0, f});
            check("file_data", file_data, r);
        end
    endtask : step

    task automatic pause();
        instr_valid = 1'b0;
        @(negedge sys_clk);
        check("done_idle", {6'h00, done, file_we}, 8'h00);
    endtask : pause

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        check("acc_rst", acc, 8'h00);
        check("flags_rst", {5'h00, zero_flag, done, file_we}, 8'h00);
        $display("test reset done");
    endtask : t_reset

    task automatic t_literal();
        step(14'h30A5);
        step(14'h3000);
        step(14'h30FF);
        pause();
        $display("test literal done");
    endtask : t_literal

    task automatic t_store();
        step(14'h00FF);
        step(14'h305A);
        step(14'h0080);
        step(14'h0085);
        pause();
        $display("test store done");
    endtask : t_store

    task automatic t_copy();
        step(14'h087F);
        step(14'h0883);
        step(14'h08FF);
        step(14'h0805);
        pause();
        $display("test copy done");
    endtask : t_copy

    task automatic t_or();
        step(14'h3000);
        step(14'h0483);
        step(14'h0086);
        step(14'h300F);
        step(14'h0485);
        step(14'h0405);
        step(14'h0885);
        pause();
        $display("test or done");
    endtask : t_or

    task automatic t_idle();
        step(14'h0000);
        step(14'h3F00);
        step(14'h0005);
        step(14'h0000);
        pause();
        $display("test idle done");
    endtask : t_idle

    // reset in mid-run must clear the file array as well as the outputs
    task automatic t_mid_reset();
        rst_n = 1'b0;
        @(negedge sys_clk);
        @(negedge sys_clk);
        check("acc_mid_rst", acc, 8'h00);
        check("flags_mid_rst", {5'h00, zero_flag, done, file_we}, 8'h00);
        rst_n = 1'b1;
        acc_m = 8'h00;
        z_m = 1'b0;
        foreach (mem[i]) mem[i] = 8'h00;
        step(14'h0885);
        step(14'h0805);
        pause();
        $display("test mid reset done");
    endtask : t_mid_reset

    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        t_reset();
        t_literal();
        t_store();
        t_copy();
        t_or();
        t_idle();
        t_mid_reset();
        finish_test();
    end

    // whole run is under a hundred cycles
    initial begin
        #20000;
        n_errors++;
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
